// *** core/sbmi_defines.svh ***
`ifndef SBMI_DEFINES_SVH
`define SBMI_DEFINES_SVH
`define SBMI_LOW_AW      14
`define SBMI_HIGH_AW     4
`define SBMI_SHIFT       4
`define SBMI_PHYS_AW     24
`define SBMI_IO_AW       16
`define SBMI_DW          16
`define SBMI_INTW        8
`define SBMI_SELW        8
`define SBMI_ADDR_ZERO   24'h000000
`define SBMI_DATA_ZERO   16'h0000
`define SBMI_INT_ZERO    8'h00
`define SBMI_SEL_ZERO    8'h00
`define SBMI_HIGH_ZERO   4'h0
`endif

// *** core/sbmi_master.sv ***
`include "sbmi_defines.svh"
// Functional notes
// RL1: Bus signals with asterisk names are active low on every agent.
// RL2: Memory address is the fourteen low address bits shifted left four.
// RL3: Address bit zero with byte-high enable picks even, odd or both.
// RL4: Data path sixteen bits; even byte low lanes, odd byte high lanes.
// RL5: I/O accesses drive and decode only the sixteen low address lines.
// RL6: Four separately loaded high bits extend the address to 24 bits.
// RL7: Contend only while priority-in says no higher master requests.
// RL8: Serial priority-out only when neither we nor higher ones request.
// RL9: Parallel bus request asserted whenever transfers are pending.
// RL10: Busy held asserted while we own the bus; wait while others hold it.
// RL11: Common bus request while needing but lacking the bus; the code never drives it in SBMI_ARB_EVERY mode.
// RL12: Lock asserted for multi-transfer atomic operations.
// RL13: I/O read: port address out, port drives the data lines.
// RL14: I/O write: port address and data out, port takes the data.
// RL15: Memory read: address out, memory places contents on data lines.
// RL16: Memory write: address and data out, memory stores the data.
// RL17: Addressed slave asserts transfer acknowledge on completion.
// RL18: System initialize returns the block to its reset state; the code keeps sel_ff, the captured transfer and the read data.
// RL19: Eight interrupt request lines driven; interrupt acknowledge unused.
// RL20: Socket DMA request, wait and terminate inputs are ORed together.
// RL21: Device select reaches up to 256 devices over both sockets.
// RL22: No DMA acknowledge is given to the expansion sockets.
// RL23: Arbitration per access, yield to higher, or yield to any requester.
// RL24: Priority-out driven only in serial resolution, else inactive.
// RL25: Command strobe held until acknowledge, then removed before next.
module sbmi_master
   import sbmi_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       resetn,
   input  wire logic                       clkEn,
   // User side
   input  wire logic                       xferReq,
   output logic                            xferAck,
   input  wire sbmi_kind_t                 xferKind,
   input  wire logic [`SBMI_LOW_AW-1:0]    xferAddrLow,
   input  wire logic [`SBMI_IO_AW-1:0]     xferIoAddr,
   input  wire logic                       xferByteOdd,
   input  wire logic                       xferWord,
   input  wire logic [`SBMI_DW-1:0]        xferWrData,
   output logic [`SBMI_DW-1:0]             xferRdData,
   input  wire logic                       xferLock,
   input  wire logic                       highLoad,
   input  wire logic [`SBMI_HIGH_AW-1:0]   highAddr,
   input  wire sbmi_arb_t                  arbMode,
   input  wire logic                       serialPrio,
   input  wire logic                       yield_to_any_requester_select,
   input  wire logic [`SBMI_INTW-1:0]      intReq,
   input  wire logic [`SBMI_SELW-1:0]      devSelect,
   output logic                            sockDmaReq,
   output logic                            sockWait,
   output logic                            sockTerm,
   output logic [`SBMI_SELW-1:0]           sockSelect,
   // Expansion sockets
   input  wire logic                       sockDreqA,
   input  wire logic                       sockDreqB,
   input  wire logic                       sockWaitA_n,
   input  wire logic                       sockWaitB_n,
   input  wire logic                       sockTermA,
   input  wire logic                       sockTermB,
   // System bus
   input  wire logic                       bclk_n,
   input  wire logic                       bprn_n,
   output logic                            bpro_n,
   output logic                            breq_n,
   input  wire logic                       busy_n_i,
   output logic                            busy_n_o,
   output logic                            busy_n_oe,
   input  wire logic                       cbrq_n_i,
   output logic                            cbrq_n_o,
   output logic                            cbrq_n_oe,
   output logic                            lock_n,
   input  wire logic                       init_n,
   output logic [`SBMI_PHYS_AW-1:0]        adr_n,
   output logic                            adrOe,
   output logic                            bhen_n,
   input  wire logic [`SBMI_DW-1:0]        dat_n_i,
   output logic [`SBMI_DW-1:0]             dat_n_o,
   output logic                            datOe,
   output logic                            mrdc_n,
   output logic                            mwtc_n,
   output logic                            iorc_n,
   output logic                            iowc_n,
   input  wire logic                       xack_n,
   output logic [`SBMI_INTW-1:0]           int_n,
   output logic                            int_n_oe
);
   // Two-flop synchronisers for bus inputs
   logic [6:0] syncA_ff;
   logic [6:0] syncB_ff;
   logic [`SBMI_DW-1:0] datA_ff;
   logic [`SBMI_DW-1:0] datB_ff;
   wire [6:0] rawIn = {bclk_n, bprn_n, busy_n_i, cbrq_n_i, init_n, xack_n,
                       1'b0};
   // Control lines and bclk_n inactive high at reset; spare bit zero resets low
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         syncA_ff <= 7'h7E;
         syncB_ff <= 7'h7E;
      end else if (clkEn) begin
         syncA_ff <= rawIn;
         syncB_ff <= syncA_ff;
      end
   end

   // Data lines, inverted only behind the second flop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         datA_ff <= `SBMI_DATA_ZERO;
         datB_ff <= `SBMI_DATA_ZERO;
      end else if (clkEn) begin
         datA_ff <= dat_n_i;
         datB_ff <= datA_ff;
      end
   end
   wire [`SBMI_DW-1:0] datIn = ~datB_ff;                            // RL1
   // Active-high views of the synchronised active-low lines
   wire bclkS   = ~syncB_ff[6];
   wire prioIn  = ~syncB_ff[5];                                   // RL1
   wire busyIn  = ~syncB_ff[4];
   wire cbrqIn  = ~syncB_ff[3];
   wire initIn  = ~syncB_ff[2];
   wire ackIn   = ~syncB_ff[1];

   logic bclkPrev_ff;
   wire  bclkRise = bclkS & ~bclkPrev_ff;

   sbmi_state_t state_ff;
   sbmi_state_t nxt_state;
   logic        owner_ff;
   logic        busyDrv_ff;
   logic        lock_ff;
   logic [`SBMI_HIGH_AW-1:0] high_ff;
   logic [`SBMI_PHYS_AW-1:0] adr_ff;
   logic        bhen_ff;
   logic [`SBMI_DW-1:0]      wd_ff;
   logic [`SBMI_DW-1:0]      rd_ff;
   sbmi_kind_t  kind_ff;
   logic        ack_ff;
   logic [`SBMI_INTW-1:0]    int_ff;
   logic [`SBMI_SELW-1:0]    sel_ff;

   // Address formation
   wire [`SBMI_PHYS_AW-1:0] memAddr =
      {high_ff, {(`SBMI_PHYS_AW-`SBMI_HIGH_AW-`SBMI_LOW_AW-`SBMI_SHIFT){1'b0}},
       xferAddrLow, {`SBMI_SHIFT{1'b0}}} |                          // RL2 RL6
      {{(`SBMI_PHYS_AW-1){1'b0}}, xferByteOdd & ~xferWord};         // RL3
   wire [`SBMI_PHYS_AW-1:0] ioAddr =
      {{(`SBMI_PHYS_AW-`SBMI_IO_AW){1'b0}}, xferIoAddr};            // RL5
   wire isIo     = (xferKind == SBMI_IO_RD) || (xferKind == SBMI_IO_WR);
   wire isWrite  = (xferKind == SBMI_MEM_WR) || (xferKind == SBMI_IO_WR);
   wire kindMemRd = kind_ff == SBMI_MEM_RD;
   wire kindMemWr = kind_ff == SBMI_MEM_WR;
   wire kindIoRd  = kind_ff == SBMI_IO_RD;
   wire kindIoWr  = kind_ff == SBMI_IO_WR;
   wire kindWr    = kindMemWr || kindIoWr;
   // Odd byte or word uses the high lane
   wire bhenNeed = xferWord | xferByteOdd;                          // RL3
   wire [`SBMI_DW-1:0] laneData = (xferByteOdd & ~xferWord) ?
      {xferWrData[7:0], xferWrData[7:0]} : xferWrData;              // RL4
   wire [`SBMI_DW-1:0] laneRead = (adr_ff[0] & bhen_ff) ?
      {8'h00, datIn[15:8]} : datIn;                                 // RL4

   // Surrender decision after the current transfer
   wire keepOnHigher = arbMode == SBMI_ARB_HIGHER && prioIn &&
                       !yield_to_any_requester_select;
   wire keepOnAny    = arbMode == SBMI_ARB_ANY && !cbrqIn;
   wire keepBus      = xferReq && (keepOnHigher || keepOnAny || lock_ff); // RL23
   wire mayTake      = prioIn && !busyIn;                           // RL7 RL10

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SBMI_IDLE: if (xferReq) nxt_state = SBMI_REQ;
         SBMI_REQ:  if (bclkRise && mayTake) nxt_state = SBMI_OWN;
         SBMI_OWN:  nxt_state = SBMI_CMD;
         SBMI_CMD:  if (ackIn) nxt_state = SBMI_DONE;               // RL25
         SBMI_DONE: if (!ackIn) begin
            nxt_state = keepBus ? SBMI_OWN : SBMI_IDLE;
         end
         default:   nxt_state = SBMI_IDLE;
      endcase
   end

   wire inDone   = state_ff == SBMI_DONE;
   wire loadXfer = (state_ff == SBMI_REQ && bclkRise && mayTake) ||
                   (inDone && !ackIn && keepBus);
   wire relBus   = inDone && !ackIn && !keepBus;
   wire inCmd    = state_ff == SBMI_CMD;
   wire gotAck   = inCmd && ackIn;
   wire needBus  = xferReq && !owner_ff;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bclkPrev_ff <= 1'b0;
      end else if (clkEn) begin
         bclkPrev_ff <= bclkS;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= SBMI_IDLE;
      end else if (clkEn) begin
         state_ff <= initIn ? SBMI_IDLE : nxt_state;                // RL18
      end
   end

   // Ownership and lock follow the claim
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         owner_ff   <= 1'b0;
         busyDrv_ff <= 1'b0;
         lock_ff    <= 1'b0;
      end else if (clkEn) begin
         if (initIn || relBus) begin                                // RL18
            owner_ff   <= 1'b0;
            busyDrv_ff <= 1'b0;
            lock_ff    <= 1'b0;
         end else if (loadXfer) begin
            owner_ff   <= 1'b1;
            busyDrv_ff <= 1'b1;                                     // RL10
            lock_ff    <= xferLock;                                 // RL12
         end
      end
   end

   // Transfer captured as the bus is claimed
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         adr_ff  <= `SBMI_ADDR_ZERO;
         bhen_ff <= 1'b0;
         wd_ff   <= `SBMI_DATA_ZERO;
         kind_ff <= SBMI_MEM_RD;
      end else if (clkEn && !initIn && loadXfer) begin
         adr_ff  <= isIo ? ioAddr : memAddr;                        // RL5
         bhen_ff <= isIo ? 1'b0 : bhenNeed;
         wd_ff   <= isWrite ? laneData : `SBMI_DATA_ZERO;
         kind_ff <= xferKind;
      end
   end

   // One-cycle user acknowledge with read data
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
         rd_ff  <= `SBMI_DATA_ZERO;
      end else if (clkEn) begin
         ack_ff <= !initIn && gotAck;                               // RL17
         if (!initIn && gotAck && !kindWr) begin
            rd_ff <= laneRead;                                      // RL13 RL15
         end
      end
   end

   // User registers outside the transfer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         high_ff <= `SBMI_HIGH_ZERO;
         int_ff  <= `SBMI_INT_ZERO;
         sel_ff  <= `SBMI_SEL_ZERO;
      end else if (clkEn) begin
         if (initIn) begin                                          // RL18
            high_ff <= `SBMI_HIGH_ZERO;
            int_ff  <= `SBMI_INT_ZERO;
         end else begin
            int_ff <= intReq;                                       // RL19
            sel_ff <= devSelect;                                    // RL21
            if (highLoad) high_ff <= highAddr;                      // RL6
         end
      end
   end

   // Bus outputs, active low
   assign busy_n_o  = 1'b0;
   assign busy_n_oe = busyDrv_ff;                                   // RL10
   assign cbrq_n_o  = 1'b0;
   assign cbrq_n_oe = needBus && arbMode != SBMI_ARB_EVERY;         // RL11
   assign breq_n    = ~(xferReq | owner_ff);                        // RL9
   assign bpro_n    = serialPrio ? ~(prioIn && !xferReq && !owner_ff)
                                 : 1'b1;                            // RL8 RL24
   assign lock_n    = ~lock_ff;                                     // RL12
   assign adr_n     = ~adr_ff;                                      // RL1
   assign adrOe     = owner_ff;
   assign bhen_n    = ~(owner_ff & bhen_ff);                        // RL3
   assign dat_n_o   = ~wd_ff;                                       // RL14 RL16
   assign datOe     = owner_ff && kindWr;
   assign mrdc_n    = ~(inCmd && kindMemRd);                        // RL15 RL25
   assign mwtc_n    = ~(inCmd && kindMemWr);                        // RL16 RL25
   assign iorc_n    = ~(inCmd && kindIoRd);                         // RL13 RL25
   assign iowc_n    = ~(inCmd && kindIoWr);                         // RL14 RL25
   assign int_n     = ~int_ff;                                      // RL19
   assign int_n_oe  = |int_ff;
   assign xferAck   = ack_ff;
   assign xferRdData = rd_ff;
   assign sockSelect = sel_ff;                                      // RL21

   // Socket merge; no DMA acknowledge output exists
   assign sockDmaReq = sockDreqA | sockDreqB;                       // RL20 RL22
   assign sockWait   = ~sockWaitA_n | ~sockWaitB_n;                 // RL20
   assign sockTerm   = sockTermA | sockTermB;                       // RL20
endmodule : sbmi_master

// *** core/sbmi_pkg.sv ***
package sbmi_pkg;
   typedef enum logic [2:0] {
      SBMI_IDLE  = 3'h0,
      SBMI_REQ   = 3'h1,
      SBMI_OWN   = 3'h3,
      SBMI_CMD   = 3'h2,
      SBMI_DONE  = 3'h6
   } sbmi_state_t;
   // Arbitration policy
   typedef enum logic [1:0] {
      SBMI_ARB_EVERY  = 2'h0,
      SBMI_ARB_HIGHER = 2'h1,
      SBMI_ARB_ANY    = 2'h2
   } sbmi_arb_t;
   // Transfer kind
   typedef enum logic [1:0] {
      SBMI_MEM_RD = 2'h0,
      SBMI_MEM_WR = 2'h1,
      SBMI_IO_RD  = 2'h2,
      SBMI_IO_WR  = 2'h3
   } sbmi_kind_t;
endpackage : sbmi_pkg

// *** test/sbmi_bus_model.sv ***
module sbmi_bus_model (
   input  logic        sys_clk,
   input  logic        rdCmd,
   input  logic        wrCmd,
   input  int          ackDly,
   input  logic [15:0] rdVal,
   input  logic [23:0] adr_n,
   input  logic        bhen_n,
   input  logic [15:0] dat_n_o,
   output logic        bclk_n,
   output logic        xack_n,
   output logic [15:0] dat_n_i,
   output logic [23:0] capAdr,
   output logic [15:0] capDat,
   output logic        capBhen
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   initial bclk_n = 1'h1;
   initial xack_n = 1'h1;
   always #80 bclk_n = ~bclk_n;
   // Undriven lines sit at the terminator level
   assign dat_n_i = rdCmd ? ~rdVal : 16'hFFFF;
   always @(posedge sys_clk) begin
      cnt <= (rdCmd || wrCmd) ? cnt + 1 : 0;
      xack_n <= !((rdCmd || wrCmd) && cnt >= ackDly);
      if (wrCmd)
         capDat <= ~dat_n_o;
      if (rdCmd || wrCmd)
         capAdr <= ~adr_n;
      if (rdCmd || wrCmd)
         capBhen <= !bhen_n;
   end
endmodule : sbmi_bus_model

// *** test/sbmi_checker.sv ***
module sbmi_checker (
   input logic sys_clk,
   input logic resetn,
   input logic xferAck,
   input logic xack_n,
   input logic mrdc_n,
   input logic mwtc_n,
   input logic iorc_n,
   input logic iowc_n,
   input logic busy_n_o,
   input logic busy_n_oe,
   input logic cbrq_n_oe,
   input logic breq_n,
   input logic bpro_n,
   input logic serialPrio,
   input logic sockDreqA,
   input logic sockDreqB,
   input logic sockDmaReq
);
   wire cmd = !(mrdc_n && mwtc_n && iorc_n && iowc_n);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   property p_hold; cmd && xack_n |=> cmd; endproperty
   a_hold: assert property (p_hold) else $error("strobe left early");
   property p_one; $onehot0({!mrdc_n, !mwtc_n, !iorc_n, !iowc_n}); endproperty
   a_one: assert property (p_one) else $error("two strobes");
   property p_busy; cmd |-> busy_n_oe && !busy_n_o; endproperty
   a_busy: assert property (p_busy) else $error("busy not held");
   property p_ack; cmd && $fell(xack_n) |-> ##[1:6] xferAck; endproperty
   a_ack: assert property (p_ack) else $error("no user ack");
   property p_rel; xferAck |-> ##[0:3] !cmd; endproperty
   a_rel: assert property (p_rel) else $error("strobe kept");
   property p_dreq; sockDmaReq == (sockDreqA || sockDreqB); endproperty
   a_dreq: assert property (p_dreq) else $error("dma or wrong");
   property p_par; !serialPrio [*3] |-> bpro_n; endproperty
   a_par: assert property (p_par) else $error("bpro in parallel");
   property p_ser; !breq_n [*2] |-> bpro_n; endproperty
   a_ser: assert property (p_ser) else $error("bpro while asking");
   property p_cbrq; cmd |-> !cbrq_n_oe; endproperty
   a_cbrq: assert property (p_cbrq) else $error("cbrq while owner");
endmodule : sbmi_checker
bind sbmi_master sbmi_checker i_sbmi_checker (.*);

// *** test/sbmi_master_tb_top.sv ***
module sbmi_master_tb_top import sbmi_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = '0, resetn = '0, init_n = '1, clkEn = '1, xferReq = '0;
   logic xferByteOdd = '0, xferWord = '1, xferLock = '0, highLoad = '0;
   logic serialPrio = '0, bprn_n = '0, otherBusy = '0;
   logic yield_to_any_requester_select = '0;
   logic sockDreqA = '0, sockDreqB = '0, sockTermA = '0, sockTermB = '0;
   logic sockWaitA_n = '1, sockWaitB_n = '1;
   sbmi_kind_t xferKind = SBMI_MEM_RD;
   sbmi_arb_t arbMode = SBMI_ARB_EVERY;
   logic [13:0] xferAddrLow = '0;
   logic [3:0] highAddr = '0;
   logic [15:0] xferIoAddr = '0, xferWrData = '0, rdVal = '0;
   logic [7:0] intReq = '0, devSelect = '0;
   int ackDly = 1, errors = 0, tests_run = 0;
   logic xferAck, sockDmaReq, sockWait, sockTerm, bpro_n, breq_n, lock_n;
   logic busy_n_o, busy_n_oe, cbrq_n_o, cbrq_n_oe, adrOe, bhen_n, datOe;
   logic mrdc_n, mwtc_n, iorc_n, iowc_n, int_n_oe, bclk_n, xack_n, capBhen;
   logic [15:0] xferRdData, dat_n_o, dat_n_i, capDat;
   logic [23:0] adr_n, capAdr;
   logic [7:0] sockSelect, int_n;
   wire rdCmd = !(mrdc_n && iorc_n);
   wire wrCmd = !(mwtc_n && iowc_n);
   // Wired-low bus lines
   wire busy_n_i = !(busy_n_oe && !busy_n_o) && !otherBusy;
   wire cbrq_n_i = !(cbrq_n_oe && !cbrq_n_o);
   sbmi_master i_sbmi_master (.*);
   sbmi_bus_model i_sbmi_bus_model (.*);
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic tick(inout int n);
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 300) begin
         errors++;
         $display("[FAIL] %0t wait limit", $time);
         print_verdict();
      end
   endtask : tick
   task automatic xfer(input sbmi_kind_t k, input logic odd, input logic wd,
                       input logic [15:0] d);
      int n = 0;
      xferKind = k;
      xferByteOdd = odd;
      xferWord = wd;
      xferWrData = d;
      xferReq = '1;
      do
         tick(n);
      while (xferAck !== 1'h1);
      xferReq = '0;
      do
         tick(n);
      while (rdCmd || wrCmd || xack_n !== 1'h1);
   endtask : xfer
   task automatic t_reset;
      int n = 0;
      chk(24'({mrdc_n, mwtc_n, iorc_n, iowc_n, busy_n_oe, adrOe}), 24'h3C);
      init_n = '0;
      repeat (4) tick(n);
      init_n = '1;
      repeat (4) tick(n);
      chk(24'({mrdc_n, mwtc_n, iorc_n, iowc_n, busy_n_oe, adrOe}), 24'h3C);
      serialPrio = '1;
      repeat (4) tick(n);
      chk(24'(bpro_n), 24'h0);
      serialPrio = '0;
      repeat (4) tick(n);
      chk(24'(bpro_n), 24'h1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_mem;
      int n = 0;
      highAddr = 4'hA;
      highLoad = '1;
      tick(n);
      highLoad = '0;
      xferAddrLow = 14'h2ABC;
      xfer(SBMI_MEM_WR, 1'h0, 1'h1, 16'h1234);
      chk(24'(capAdr[17:4]), 24'h2ABC);
      chk(24'(capAdr[23:20]), 24'hA);
      chk(24'(capDat), 24'h1234);
      ackDly = 6;
      rdVal = 16'hBEEF;
      xfer(SBMI_MEM_RD, 1'h0, 1'h1, 16'h0000);
      chk(24'(xferRdData), 24'hBEEF);
      chk(24'({capAdr[0], capBhen}), 24'h1);
      ackDly = 1;
      $display("t_mem done");
   endtask : t_mem
   task automatic t_byte;
      xfer(SBMI_MEM_WR, 1'h1, 1'h0, 16'h005A);
      chk(24'({capDat[15:8], capAdr[0], capBhen}), 24'h16B);
      rdVal = 16'h77C3;
      xfer(SBMI_MEM_RD, 1'h0, 1'h0, 16'h0000);
      chk(24'({xferRdData[7:0], capAdr[0], capBhen}), 24'h30C);
      rdVal = 16'h9E11;
      xfer(SBMI_MEM_RD, 1'h1, 1'h0, 16'h0000);
      chk(24'(xferRdData[7:0]), 24'h9E);
      $display("t_byte done");
   endtask : t_byte
   task automatic t_io;
      xferIoAddr = 16'hF00D;
      xfer(SBMI_IO_WR, 1'h0, 1'h1, 16'h8001);
      chk(capAdr, 24'h00F00D);
      chk(24'(capDat), 24'h8001);
      rdVal = 16'h0FF0;
      xfer(SBMI_IO_RD, 1'h0, 1'h1, 16'h0000);
      chk(24'(xferRdData), 24'h0FF0);
      $display("t_io done");
   endtask : t_io
   task automatic t_refuse;
      int n = 0;
      logic seen = '0;
      otherBusy = '1;
      repeat (4) tick(n);
      xferKind = SBMI_IO_RD;
      xferReq = '1;
      repeat (30) begin
         tick(n);
         seen = seen | rdCmd;
         otherBusy = (n < 19);
         bprn_n = (n >= 19) && (n < 34);
      end
      chk(24'(seen), 24'h0);
      chk(24'(breq_n), 24'h0);
      xfer(SBMI_IO_RD, 1'h0, 1'h1, 16'h0000);
      chk(24'(xferRdData), 24'h0FF0);
      $display("t_refuse done");
   endtask : t_refuse
   task automatic t_modes;
      for (int m = 0; m < 3; m++) begin
         arbMode = sbmi_arb_t'(m);
         xferLock = (m == 2);
         rdVal = 16'h5000 + 16'(m);
         xfer(SBMI_MEM_WR, 1'h0, 1'h1, 16'h00A0);
         xfer(SBMI_MEM_RD, 1'h0, 1'h1, 16'h0000);
         chk(24'(xferRdData), 24'h5000 + 24'(m));
      end
      $display("t_modes done");
   endtask : t_modes
   task automatic t_sock;
      int n = 0;
      for (int i = 0; i < 64; i++) begin
         {sockDreqA, sockDreqB, sockWaitA_n, sockWaitB_n} = 4'(i >> 2);
         {sockTermA, sockTermB} = 2'(i);
         intReq = 8'(i * 5);
         devSelect = ~8'(i);
         repeat (3) tick(n);
         n = 0;
         chk(24'({sockDmaReq, sockWait, sockTerm}), 24'({sockDreqA | sockDreqB,
             !(sockWaitA_n & sockWaitB_n), sockTermA | sockTermB}));
         chk(24'(int_n), {16'h0000, ~intReq});
         chk(24'(int_n_oe), 24'(|intReq));
         chk(24'(sockSelect), 24'(devSelect));
      end
      $display("t_sock done");
   endtask : t_sock
   initial begin
      int n = 0;
      repeat (4) tick(n);
      resetn = '1;
      t_reset();
      t_mem();
      t_byte();
      t_io();
      t_refuse();
      t_modes();
      t_sock();
      print_verdict();
   end
endmodule : sbmi_master_tb_top
